// file: shared/tap_params.svh
// Constants for the memory boundary scan test port.
//
// Contract
// - Inputs taken on test clock rise, outputs fall.
// - Mode select steers controller on rising edges.
// - Serial input feeds selected register's top bit.
// - Serial output: selected LSB, enabled only shifting.
// - Instruction picks exactly one register in path.
// - Five high mode-select rises reach reset state.
// - Port reset never disturbs memory operation.
// - Power-up reset, serial output high impedance.
// - Instruction register three bits, serially loaded.
// - Reset state loads identification instruction.
// - Capture-IR loads low bits with binary 01.
// - Bypass is one bit, cleared under bypass.
// - Scan register has one cell per ball.
// - Capture-DR snapshots ring; Shift-DR shifts it.
// - Three sampling instructions select scan register.
// - Identification instruction captures fixed 32-bit code.
// - All-zero instruction samples, memory outputs floated.
// - Sample-Z selects scan register, floats outputs.
// - Update-DR under sample changes nothing at all.
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define IR_W          3
`define IR_CAPTURE    3'h1
`define INSN_EXTEST   3'h0
`define INSN_IDCODE   3'h1
`define INSN_SAMPLE_Z 3'h2
`define INSN_SAMPLE   3'h4
`define INSN_BYPASS   3'h7
`define ID_W          32
`define RESET_RISES   3'h5

`endif

// file: shared/tap_pkg.sv
// Types shared by the memory boundary scan test port.
package tap_pkg;

  // The sixteen controller states.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR,
    ST_UPD_IR
  } tap_state_type;

endpackage : tap_pkg

// file: hdl/sram_boundary_scan_tap.sv
// Boundary scan test access port for a pipelined memory.
`timescale 1ns/1ps
`include "tap_params.svh"

module sram_boundary_scan_tap #(
  parameter int          RING_W  = 16,           // Input and two-way balls.
  parameter logic [31:0] ID_CODE = 32'h0a5a_5001 // Arbitrary value.
) (
  input  wire logic              sys_clk,     // 250 MHz system clock.
  input  wire logic              rstn,        // Power-up reset, active low.
  input  wire logic              tck,         // Test clock pin.
  input  wire logic              tms,         // Mode select, pulled up.
  input  wire logic              tdi,         // Serial data in, pulled up.
  input  wire logic [RING_W-1:0] ring_in,     // Live levels of the balls.
  output      logic              tdo,         // Serial data out.
  output      logic              tdo_oe,      // High while tdo is driven.
  output      logic              mem_out_hiz  // Forces memory outputs off.
);
  import tap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the parameters.

  // The shift path slices off the bottom cell, so two cells are the least
  // that the boundary scan register can serve.
  if (RING_W < 2) begin : g_bad_width
    $error("RING_W must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Everything the port remembers, registered together.
  typedef struct packed {
    logic              tck_m;  // First synchroniser stage, clock pin.
    logic              tck_s;  // Second stage.
    logic              tck_p;  // Delayed copy for edge finding.
    logic              tms_m;  // First stage, mode select.
    logic              tms_s;  // Second stage.
    logic              tdi_m;  // First stage, serial input.
    logic              tdi_s;  // Second stage.
    logic [RING_W-1:0] ring_m; // First stage, ball levels.
    logic [RING_W-1:0] ring_s; // Second stage.
    tap_state_type     st;     // Controller state.
    logic [2:0]        ir;     // Current instruction.
    logic [2:0]        ir_sh;  // Instruction shift stage.
    logic              byp;    // Bypass cell.
    logic [31:0]       idr;    // Identification register.
    logic [RING_W-1:0] bsr;    // Boundary scan register.
    logic              tdo;    // Serial output flop.
    logic              oe;     // Serial output enable flop.
    logic              hiz;    // Memory output float flop.
    logic [2:0]        ones;   // Rises seen with mode select high.
  } tap_q_type;

  tap_q_type q;    // Registered state.
  tap_q_type d;    // Next state.
  logic      rise; // One-cycle pulse on a test clock rising edge.
  logic      fall; // One-cycle pulse on a test clock falling edge.

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Controller transition for one rising edge.
  function automatic tap_state_type next_st(input tap_state_type s,
                                            input logic m);
    tap_state_type n;
    n = ST_RESET;
    unique case (s)
      ST_RESET:  n = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = m ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: n = m ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: n = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = m ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: n = m ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: n = m ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: n = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = m ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
    endcase
    return n;
  endfunction : next_st

  // True when the instruction routes through the boundary scan register.
  function automatic logic sel_bsr(input logic [2:0] i);
    return (i == `INSN_EXTEST) || (i == `INSN_SAMPLE) ||
           (i == `INSN_SAMPLE_Z);
  endfunction : sel_bsr

  // True when the instruction floats the memory outputs.
  function automatic logic float_out(input logic [2:0] i);
    return (i == `INSN_EXTEST) || (i == `INSN_SAMPLE_Z);
  endfunction : float_out

  ////////////////////////////////////////////////////////////////////////////
  // Edge finding on the synchronised test clock.

  // Only second-stage and later copies are compared. A test clock held low
  // gives no edges, so an unused port never moves.
  assign rise = q.tck_s & ~q.tck_p;
  assign fall = ~q.tck_s & q.tck_p;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Every pin passes two flops; all action but the float flop waits for an edge pulse.
  always_comb begin
    d        = q;
    d.tck_m  = tck;
    d.tck_s  = q.tck_m;
    d.tck_p  = q.tck_s;
    d.tms_m  = tms;
    d.tms_s  = q.tms_m;
    d.tdi_m  = tdi;
    d.tdi_s  = q.tdi_m;
    d.ring_m = ring_in;
    d.ring_s = q.ring_m;
    // The float request follows the held instruction only.
    d.hiz    = float_out(q.ir);
    if (rise) begin
      // Mode select is taken only at rising edges.
      d.st = next_st(q.st, q.tms_s);
      // Count consecutive high mode-select rises, saturating at five.
      if (!q.tms_s) begin
        d.ones = 3'h0;
      end else if (q.ones != `RESET_RISES) begin
        d.ones = q.ones + 3'h1;
      end
      unique case (q.st)
        ST_CAP_IR: begin
          // Fixed pattern lets a tester find a broken chain.
          d.ir_sh = `IR_CAPTURE;
        end
        ST_SHF_IR: begin
          // Serial input enters at the top, three bits long.
          d.ir_sh = {q.tdi_s, q.ir_sh[2:1]};
        end
        ST_UPD_IR: begin
          d.ir = q.ir_sh;
        end
        ST_CAP_DR: begin
          // Only the register the instruction picks is loaded.
          if (sel_bsr(q.ir)) begin
            d.bsr = q.ring_s;
          end else if (q.ir == `INSN_IDCODE) begin
            d.idr = ID_CODE;
          end else begin
            d.byp = 1'b0;
          end
        end
        ST_SHF_DR: begin
          // Exactly one register moves; the others hold.
          if (sel_bsr(q.ir)) begin
            d.bsr = {q.tdi_s, q.bsr[RING_W-1:1]};
          end else if (q.ir == `INSN_IDCODE) begin
            d.idr = {q.tdi_s, q.idr[31:1]};
          end else begin
            d.byp = q.tdi_s;
          end
        end
        default: begin
          // Update-DR has no preload to apply, so it holds.
        end
      endcase
      // Entering or staying in reset restores the identify instruction.
      if (d.st == ST_RESET) begin
        d.ir = `INSN_IDCODE;
      end
    end
    if (fall) begin
      // Output moves only on falling edges, from the register's low end.
      d.oe = (q.st == ST_SHF_DR) || (q.st == ST_SHF_IR);
      if (q.st == ST_SHF_IR) begin
        d.tdo = q.ir_sh[0];
      end else if (sel_bsr(q.ir)) begin
        d.tdo = q.bsr[0];
      end else if (q.ir == `INSN_IDCODE) begin
        d.tdo = q.idr[0];
      end else begin
        d.tdo = q.byp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Power-up reset leaves the output floated and the memory untouched;
  // nothing here reaches the memory's own datapath.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.st    <= ST_RESET;
      q.ir    <= `INSN_IDCODE;
    end else begin
      q <= d;
    end
  end

  assign tdo         = q.tdo;
  assign tdo_oe      = q.oe;
  assign mem_out_hiz = q.hiz;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Five high rises always end in reset.
  reset_walk_a: assert property (
    (q.ones == `RESET_RISES) |-> (q.st == ST_RESET))
    else $error("five high rises did not reach reset");

  // Serial output moves only after a falling edge.
  tdo_fall_a: assert property (
    ($changed(q.tdo) || $changed(q.oe)) |-> $past(fall))
    else $error("serial output moved without falling edge");

  // Output enable only after a falling edge in a shift state.
  oe_shift_a: assert property (
    $rose(q.oe) |-> ($past(fall) &&
      (($past(q.st) == ST_SHF_DR) || ($past(q.st) == ST_SHF_IR))))
    else $error("output enabled outside shift");

  // Capture-IR leaves 01 in the low bits.
  ir_capture_a: assert property (
    (rise && q.st == ST_CAP_IR) |=> (q.ir_sh[1:0] == 2'h1))
    else $error("capture pattern wrong");

  // Reset state holds the identify instruction.
  ir_reset_a: assert property (
    (q.st == ST_RESET) |-> (q.ir == `INSN_IDCODE))
    else $error("reset state lacks identify instruction");

  // Bypass capture clears the cell.
  bypass_clear_a: assert property (
    (rise && q.st == ST_CAP_DR && q.ir == `INSN_BYPASS) |=> !q.byp)
    else $error("bypass not cleared");

  // Identify capture loads the code.
  id_load_a: assert property (
    (rise && q.st == ST_CAP_DR && q.ir == `INSN_IDCODE)
      |=> (q.idr == ID_CODE))
    else $error("identification code not captured");

  // Shift puts serial input into the scan register's top cell.
  shift_msb_a: assert property (
    (rise && q.st == ST_SHF_DR && sel_bsr(q.ir))
      |=> (q.bsr[RING_W-1] == $past(q.tdi_s)))
    else $error("serial input not at top cell");

  // Update-DR leaves the scan register alone.
  update_hold_a: assert property (
    (rise && q.st == ST_UPD_DR) |=> $stable(q.bsr))
    else $error("update changed scan register");

  // Float request follows the held instruction one cycle on.
  float_out_a: assert property (
    (float_out(q.ir) && $stable(q.ir)) |=> mem_out_hiz)
    else $error("memory outputs not floated");

  // Capture under a sampling instruction takes the synchronised ring.
  ring_snapshot_a: assert property (
    (rise && q.st == ST_CAP_DR && sel_bsr(q.ir))
      |=> (q.bsr == $past(q.ring_s)))
    else $error("ring snapshot not captured");

  // While the scan register shifts, the other data registers hold.
  single_path_a: assert property (
    (rise && q.st == ST_SHF_DR && sel_bsr(q.ir))
      |=> ($stable(q.idr) && $stable(q.byp)))
    else $error("more than one register shifted");

endmodule : sram_boundary_scan_tap

// file: verif/tap_host.sv
// Behavioural scan controller that drives the test port's link.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tap_host (
  input  wire logic sys_clk, // Paces the link from its falling edges.
  input  wire logic tdo_w,   // Resolved serial output line.
  output      logic tck,     // Test clock, low between frames.
  output      logic tms,     // Mode select.
  output      logic tdi,     // Serial data in.
  output      logic smp_stb, // Toggles when tdo has been sampled.
  output      logic smp_val  // The sampled serial output.
);
  // The clock rests low so the port sees no edges when unused.
  initial begin
    tck     = 1'b0;
    tms     = 1'b1;
    tdi     = 1'b1;
    smp_stb = 1'b0;
    smp_val = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One 160 ns test clock period. Data is read just before the rise,
  // long after the value launched by the previous fall has settled.
  task automatic step(input logic m, input logic d, input logic smp);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (10) @(negedge sys_clk);
    if (smp) begin
      smp_val = tdo_w;
      smp_stb = ~smp_stb;
    end
    tck = 1'b1;
    repeat (20) @(negedge sys_clk);
    tck = 1'b0;
    repeat (9) @(negedge sys_clk);
  endtask : step
  // Five rises with mode select high reach reset, one low goes idle.
  task automatic to_idle();
    repeat (5) step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
  endtask : to_idle
endmodule : tap_host

// file: verif/sram_boundary_scan_tap_test.sv
// Self-checking bench for the memory boundary scan test port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module sram_boundary_scan_tap_test;
  localparam int          RW = 16;           // Ring width used here.
  localparam logic [31:0] ID = 32'h0c3a_9e15; // Arbitrary code value.
  logic          sys_clk, rstn, tck, tms, tdi, tdo, tdo_oe, mem_out_hiz;
  logic          smp_stb, smp_val, tdo_w;
  logic [RW-1:0] ring_in;                    // Ball levels.
  logic [31:0]   lfsr_q;                     // Random source.
  logic [63:0]   din;                        // Serial data for a scan.
  logic [2:0]    codes[6] = '{3'h0, 3'h2, 3'h4, 3'h3, 3'h7, 3'h1};
  logic          exp_q[$];                   // Expected serial bits.
  int            err_count, checks_done;
  // A released output line floats, so it can never match a bit.
  assign tdo_w = tdo_oe ? tdo : 1'bz;
  sram_boundary_scan_tap #(.RING_W(RW), .ID_CODE(ID)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe),
    .mem_out_hiz(mem_out_hiz));
  tap_host host (.sys_clk(sys_clk), .tdo_w(tdo_w), .tck(tck), .tms(tms),
    .tdi(tdi), .smp_stb(smp_stb), .smp_val(smp_val));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Walks capture, shift of n bits and update, noting each bit expected.
  task automatic scan(input logic ir, input int n, input logic [63:0] d,
                      input logic [63:0] exp);
    host.step(1'b1, 1'b1, 1'b0);
    if (ir) host.step(1'b1, 1'b1, 1'b0);
    host.step(1'b0, 1'b1, 1'b0);
    host.step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp[i]);
      host.step(i == n - 1, d[i], 1'b1);
    end
    host.step(1'b1, 1'b1, 1'b0);
    host.step(1'b0, 1'b1, 1'b0);
  endtask : scan
  ////////////////////////////////////////////////////////////////////////
  // Each sample taken by the controller is matched with the oldest note.
  always @(smp_stb) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) chk("tdo unexpected", 1'b0, 1'bx);
      else chk("tdo", exp_q.pop_front(), smp_val);
    end
  end
  // A hang is cut short and counted.
  initial begin
    repeat (100000) @(posedge sys_clk);
    chk("run finished", 1'b1, 1'b0);
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    ring_in = '0;
    lfsr_q = 32'he1d0;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("tdo_oe", 1'b0, tdo_oe);
    chk("mem_out_hiz", 1'b0, mem_out_hiz);
    host.to_idle();
    din = {lfsr_q, lfsr_q};
    scan(1'b0, 36, din, {din[31:0], ID});
    foreach (codes[k]) begin
      lfsr_q = lfsr_next(lfsr_q);
      @(negedge sys_clk) ring_in = lfsr_q[RW-1:0];
      scan(1'b1, 3, {61'h0, codes[k]}, 64'h1);
      chk("mem_out_hiz", codes[k] == 3'h0 || codes[k] == 3'h2,
          mem_out_hiz);
      lfsr_q = lfsr_next(lfsr_q);
      // Bit seven set leaves a one in the bypass cell after a bypass
      // scan, so the next bypass capture must visibly clear it.
      din = {lfsr_q, ~lfsr_q} | 64'h80;
      if (codes[k] == 3'h1) scan(1'b0, 36, din, {din[31:0], ID});
      else if (codes[k][0]) scan(1'b0, 8, din, {din[62:0], 1'b0});
      else scan(1'b0, RW + 4, din, (din << RW) | 64'(ring_in));
      chk("tdo_oe", 1'b0, tdo_oe);
      chk("mem_out_hiz", codes[k] == 3'h0 || codes[k] == 3'h2,
          mem_out_hiz);
    end
    // A mode-select reset must drop the floated outputs and bring back ID.
    scan(1'b1, 3, 64'h0, 64'h1);
    chk("mem_out_hiz", 1'b1, mem_out_hiz);
    host.to_idle();
    chk("mem_out_hiz", 1'b0, mem_out_hiz);
    scan(1'b0, 32, din, {32'h0, ID});
    chk("queue empty", 1'b1, exp_q.size() == 0);
    print_verdict();
  end
endmodule : sram_boundary_scan_tap_test
